// ==== logic/ctl_port_pkg.sv ====
// package for the control serial port master block
// assumes a single 250 MHz core clock and an AXI4-Lite register bus
package ctl_port_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_CTRL   = 8'h04;
  localparam logic [7:0] OFS_TXDATA = 8'h08;
  localparam logic [7:0] OFS_RXDATA = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_PINS   = 8'h14;

  // ==========================================================
  // field positions and reset values
  localparam int          CTRL_START     = 0;
  localparam int          CTRL_TWO_BYTES = 1;
  localparam int          MODE_INVERT    = 5;
  localparam int          PINS_ENABLE    = 0;
  localparam int          PINS_RESET     = 1;
  localparam int          STAT_BUSY      = 0;
  localparam int          STAT_DONE      = 1;
  localparam int          STAT_IRQ       = 2;
  localparam logic [7:0]  MODE_RESET     = 8'h2f;
  localparam logic [1:0]  PINS_RESET_VAL = 2'h0;

  // ==========================================================
  // timing
  localparam int          DIV_RATIO      = 32;
  localparam int          HALF_DIV       = DIV_RATIO / 2;

  // ==========================================================
  // axi response codes
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ==========================================================
  // command to and status from the shifter
  typedef struct packed {
    logic       two_bytes;
    logic [7:0] first;
    logic [7:0] second;
    logic       invert;
  } shift_cmd_s;

  typedef struct packed {
    logic       busy;
    logic       done;
    logic [7:0] last_rx;
  } shift_stat_s;

endpackage

// ==== logic/ctl_port_shifter.sv ====
// shift engine for the control serial port, msb first, one or two bytes
// assumes the caller holds the command stable while start is high
`timescale 1ns/10ps
module ctl_port_shifter #(
  parameter int DIV = 32
) (
  // clock and reset
  input  wire logic                     CORE_CLK,
  input  wire logic                     RST_B,
  // command
  input  wire logic                     START,
  input  wire ctl_port_pkg::shift_cmd_s CMD,
  output      ctl_port_pkg::shift_stat_s STAT,
  // serial pins
  output      logic                     SCLK,
  output      logic                     SDOUT,
  input  wire logic                     SDIN
);
  import ctl_port_pkg::*;

  // refuse dividers the half-period counter cannot serve
  if (DIV < 4 || (DIV % 2) != 0)
  begin : g_bad_div
    $error("divider must be even and at least four");
  end

  localparam int HALF = DIV / 2;
  localparam int CW   = $clog2(HALF);

  typedef enum logic [1:0] {IDLE, SHIFT, FINISH} state_e;

  state_e          state;
  logic [CW-1:0]   div_cnt;
  logic            phase;
  logic [3:0]      bit_cnt;
  logic [15:0]     tx_sr;
  logic [7:0]      rx_sr;
  logic            two;
  logic            inv;
  logic            done;
  logic [7:0]      last_rx;

  // ==========================================================
  // decode
  wire             tick     = (div_cnt == CW'(HALF - 1));
  wire [3:0]       last_bit = two ? 4'hf : 4'h7;
  wire             idle_lvl = inv;

  // ==========================================================
  // sequencing
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state   <= IDLE;
      div_cnt <= '0;
      phase   <= 1'b0;
      bit_cnt <= 4'h0;
      tx_sr   <= 16'h0000;
      rx_sr   <= 8'h00;
      two     <= 1'b0;
      inv     <= 1'b1;
      done    <= 1'b0;
      last_rx <= 8'h00;
      SCLK    <= 1'b1;
      SDOUT   <= 1'b1;
    end
    else
    begin
      unique case (state)
        IDLE:
        begin
          SCLK    <= CMD.invert;
          div_cnt <= '0;
          if (START)
          begin
            state   <= SHIFT;
            two     <= CMD.two_bytes;
            inv     <= CMD.invert;
            tx_sr   <= {CMD.first, CMD.second};
            bit_cnt <= 4'h0;
            phase   <= 1'b0;
            done    <= 1'b0;
          end
        end
        SHIFT:
        begin
          div_cnt <= tick ? '0 : div_cnt + CW'(1);
          if (tick)
          begin
            phase <= ~phase;
            SCLK  <= phase ? idle_lvl : ~idle_lvl;
            if (!phase)
            begin
              // leaving rest: launch the next bit
              SDOUT <= tx_sr[15];
              tx_sr <= {tx_sr[14:0], 1'b0};
            end
            else
            begin
              // back to rest: sample, stop after the last bit
              rx_sr <= {rx_sr[6:0], SDIN};
              if (bit_cnt == last_bit)
                state <= FINISH;
              else
                bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        FINISH:
        begin
          state   <= IDLE;
          done    <= 1'b1;
          last_rx <= rx_sr;
        end
        default:
          state <= IDLE;
      endcase
    end
  end

  assign STAT.busy    = (state != IDLE);
  assign STAT.done    = done;
  assign STAT.last_rx = last_rx;

endmodule // ctl_port_shifter

// ==== logic/ctl_port_master.sv ====
// control serial port master with axi4-lite registers
// assumes the transceiver samples on the clock edge opposite to launch
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module ctl_port_master #(
  parameter int DIV = ctl_port_pkg::DIV_RATIO
) (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST_B,
  // axi4-lite write address
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output      logic        AWREADY,
  // axi4-lite write data
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output      logic        WREADY,
  // axi4-lite write response
  output      logic [1:0]  BRESP,
  output      logic        BVALID,
  input  wire logic        BREADY,
  // axi4-lite read
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output      logic        ARREADY,
  output      logic [31:0] RDATA,
  output      logic [1:0]  RRESP,
  output      logic        RVALID,
  input  wire logic        RREADY,
  // control serial port
  output      logic        PORT_CLK,
  output      logic        PORT_TXD,
  input  wire logic        PORT_RXD,
  output      logic        PORT_SELECT_ENABLE_B,
  // transceiver discrete lines
  output      logic        TRANSCEIVER_RESET_B,
  input  wire logic        LEVEL_ONE_IRQ_INPUT_B
);
  import ctl_port_pkg::*;

  logic [7:0]   mode;
  logic [15:0]  tx_data;
  logic         two_bytes;
  logic [1:0]   pins;
  logic         start;
  logic         done_flag;
  logic         done_d;
  logic         aw_held;
  logic         w_held;
  logic [7:0]   aw_addr;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;
  shift_stat_s  stat;
  shift_cmd_s   cmd;

  // ==========================================================
  // write decode
  wire          do_write   = aw_held && w_held && !BVALID;
  wire          hit_mode   = (aw_addr == OFS_MODE);
  wire          hit_ctrl   = (aw_addr == OFS_CTRL);
  wire          hit_tx     = (aw_addr == OFS_TXDATA);
  wire          hit_pins   = (aw_addr == OFS_PINS);
  wire          hit_stat   = (aw_addr == OFS_STATUS);
  wire          w_known    = hit_mode | hit_ctrl | hit_tx | hit_pins | hit_stat |
                             (aw_addr == OFS_RXDATA);
  wire          start_req  = do_write && hit_ctrl && w_strb[0] && w_data[CTRL_START];
  wire          clr_done   = do_write && hit_stat && w_strb[0] && w_data[STAT_DONE];
  wire          done_rise  = stat.done && !done_d;

  // ==========================================================
  // read decode
  wire [31:0]   rd_mode    = {24'h000000, mode};
  wire [31:0]   rd_ctrl    = {30'h0, two_bytes, stat.busy};
  wire [31:0]   rd_tx      = {16'h0000, tx_data};
  wire [31:0]   rd_rx      = {24'h000000, stat.last_rx};
  wire [31:0]   rd_stat    = {29'h0, ~LEVEL_ONE_IRQ_INPUT_B, done_flag, stat.busy};
  wire [31:0]   rd_pins    = {30'h0, pins};
  wire          r_known    = (ARADDR == OFS_MODE) | (ARADDR == OFS_CTRL) |
                             (ARADDR == OFS_TXDATA) | (ARADDR == OFS_RXDATA) |
                             (ARADDR == OFS_STATUS) | (ARADDR == OFS_PINS);
  wire [31:0]   rd_value   = (ARADDR == OFS_MODE)   ? rd_mode :
                             (ARADDR == OFS_CTRL)   ? rd_ctrl :
                             (ARADDR == OFS_TXDATA) ? rd_tx   :
                             (ARADDR == OFS_RXDATA) ? rd_rx   :
                             (ARADDR == OFS_STATUS) ? rd_stat :
                             (ARADDR == OFS_PINS)   ? rd_pins : 32'h00000000;

  assign AWREADY = !aw_held;
  assign WREADY  = !w_held;
  assign ARREADY = !RVALID;

  // ==========================================================
  // write channel capture and response
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      BVALID  <= 1'b0;
      BRESP   <= RESP_OKAY;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY)
      begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (do_write)
      begin
        BVALID  <= 1'b1;
        BRESP   <= w_known ? RESP_OKAY : RESP_SLVERR;
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
      else if (BVALID && BREADY)
        BVALID <= 1'b0;
    end
  end

  // ==========================================================
  // registers written by software
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      mode      <= MODE_RESET;
      tx_data   <= 16'h0000;
      two_bytes <= 1'b0;
      pins      <= PINS_RESET_VAL;
    end
    else if (do_write)
    begin
      if (hit_mode && w_strb[0])
        mode <= w_data[7:0];
      if (hit_tx && w_strb[0])
        tx_data[7:0] <= w_data[7:0];
      if (hit_tx && w_strb[1])
        tx_data[15:8] <= w_data[15:8];
      if (hit_ctrl && w_strb[0])
        two_bytes <= w_data[CTRL_TWO_BYTES];
      if (hit_pins && w_strb[0])
        pins <= w_data[1:0];
    end
  end

  // ==========================================================
  // start pulse and done flag, set wins over clear
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      start     <= 1'b0;
      done_d    <= 1'b0;
      done_flag <= 1'b0;
    end
    else
    begin
      start     <= start_req && !stat.busy;
      done_d    <= stat.done;
      done_flag <= done_rise ? 1'b1 : (clr_done ? 1'b0 : done_flag);
    end
  end

  // ==========================================================
  // read channel
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      RVALID <= 1'b0;
      RDATA  <= 32'h00000000;
      RRESP  <= RESP_OKAY;
    end
    else if (ARVALID && ARREADY)
    begin
      RVALID <= 1'b1;
      RDATA  <= rd_value;
      RRESP  <= r_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (RVALID && RREADY)
      RVALID <= 1'b0;
  end

  // ==========================================================
  // shifter and pins
  assign cmd.two_bytes = two_bytes;
  assign cmd.first     = two_bytes ? tx_data[15:8] : tx_data[7:0];
  assign cmd.second    = tx_data[7:0];
  assign cmd.invert    = mode[MODE_INVERT];

  ctl_port_shifter #(
    .DIV (DIV)
  ) u_shifter (
    .CORE_CLK (CORE_CLK),
    .RST_B    (RST_B),
    .START    (start),
    .CMD      (cmd),
    .STAT     (stat),
    .SCLK     (PORT_CLK),
    .SDOUT    (PORT_TXD),
    .SDIN     (PORT_RXD)
  );

  assign PORT_SELECT_ENABLE_B = ~pins[PINS_ENABLE];
  assign TRANSCEIVER_RESET_B  = ~pins[PINS_RESET];

endmodule // ctl_port_master

// ==== dv/ctl_port_master_props.sv ====
// concurrent checks on the control serial port master pins
// assumes frames run only in inverted clock mode
`timescale 1ns/10ps
module ctl_port_master_props #(
  parameter int DIV = 32
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // watched pins
  input wire logic BVALID,
  input wire logic PORT_CLK,
  input wire logic PORT_TXD,
  input wire logic PORT_SELECT_ENABLE_B,
  input wire logic TRANSCEIVER_RESET_B
);
  localparam int HALF = DIV / 2;
  logic       prev;
  logic [7:0] run;
  logic [7:0] since_b;
  logic [4:0] nbits;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // =====
  // cycle counters
  always_ff @(posedge CORE_CLK or negedge RST_B)
    if (!RST_B)
    begin
      prev    <= 1'b1;
      run     <= 8'h00;
      since_b <= 8'hff;
      nbits   <= 5'h00;
    end
    else
    begin
      prev    <= PORT_CLK;
      run     <= (PORT_CLK != prev) ? 8'h00 : run + {7'h00, run != 8'hff};
      since_b <= BVALID ? 8'h00 : since_b + {7'h00, since_b != 8'hff};
      nbits   <= (prev && !PORT_CLK) ? nbits + 5'h01 : ((int'(run) == 2 * HALF) ? 5'h00 : nbits);
    end
  // =====
  // properties
  property p_low_half;
    $fell(PORT_CLK) && !PORT_SELECT_ENABLE_B |-> ##HALF $rose(PORT_CLK);
  endproperty
  a_low_half: assert property (p_low_half)
    else $error("shift clock low phase has wrong length");
  property p_high_half;
    $fell(PORT_CLK) |-> int'(run) >= HALF - 1;
  endproperty
  a_high_half: assert property (p_high_half)
    else $error("shift clock high phase too short");
  property p_txd_rise;
    $rose(PORT_CLK) |-> $stable(PORT_TXD);
  endproperty
  a_txd_rise: assert property (p_txd_rise)
    else $error("data changed at sampling edge");
  property p_txd_low;
    $fell(PORT_CLK) |-> ##2 $stable(PORT_TXD) [*8];
  endproperty
  a_txd_low: assert property (p_txd_low)
    else $error("data moved during low phase");
  property p_reset_pin;
    $changed(TRANSCEIVER_RESET_B) |-> ##[0:3] BVALID;
  endproperty
  a_reset_pin: assert property (p_reset_pin)
    else $error("transceiver reset moved without a write");
  property p_sel_pin;
    $changed(PORT_SELECT_ENABLE_B) |-> ##[0:3] BVALID;
  endproperty
  a_sel_pin: assert property (p_sel_pin)
    else $error("select moved without a write");
  property p_start;
    $fell(PORT_CLK) && int'(run) >= HALF |-> since_b <= 8'h40;
  endproperty
  a_start: assert property (p_start)
    else $error("frame began without a start write");
  property p_frame;
    PORT_CLK && int'(run) == 2 * HALF && nbits != 5'h00 |-> nbits == 5'h08 || nbits == 5'h10;
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame bit count not 8 or 16");
endmodule // ctl_port_master_props

bind ctl_port_master ctl_port_master_props #(.DIV(DIV)) i_ctl_port_master_props (.*);

// ==== dv/xcvr_model.sv ====
// behavioural transceiver on the far side of the control serial port
// assumes inverted clock mode: launch on falling, sample on rising
`timescale 1ns/10ps
module xcvr_model (
  // control serial port
  input  wire logic PORT_CLK,
  input  wire logic PORT_TXD,
  input  wire logic PORT_SELECT_ENABLE_B,
  output      logic PORT_RXD,
  // discrete lines
  input  wire logic TRANSCEIVER_RESET_B,
  input  wire logic line_event,
  output      logic LEVEL_ONE_IRQ_INPUT_B
);
  logic [3:0]  nreg [8];
  logic [7:0]  breg [16];
  logic [15:0] sh;
  logic [7:0]  out;
  logic [7:0]  pend = 8'h00;
  logic        last = 1'b0;
  logic        irq_pend = 1'b0;
  int          cnt;
  wire         sel = !PORT_SELECT_ENABLE_B;
  // released line shows the inverse of its last bit
  assign PORT_RXD = sel ? out[7] : ~last;
  assign LEVEL_ONE_IRQ_INPUT_B = ~(irq_pend & nreg[4][0]);
  always @(negedge TRANSCEIVER_RESET_B)
  begin
    foreach (nreg[i]) nreg[i] = 4'h0;
    foreach (breg[i]) if (i != 4 && i != 5) breg[i] = 8'h00;
    irq_pend = 1'b0;
  end
  always @(posedge line_event) irq_pend = 1'b1;
  always @(negedge PORT_SELECT_ENABLE_B)
  begin
    cnt = 0;
    out = pend;
    pend = 8'h00;
  end
  always @(posedge PORT_CLK) if (sel)
  begin
    sh = {sh[14:0], PORT_TXD};
    cnt++;
  end
  // the first falling edge of a frame shows the msb already loaded
  always @(negedge PORT_CLK) if (sel && cnt != 0)
    out = (cnt == 8 && sh[7:4] == 4'hf) ? breg[sh[3:0]] : out << 1;
  always @(posedge PORT_SELECT_ENABLE_B)
  begin
    last = out[7];
    if (cnt == 8 && !sh[7]) nreg[sh[6:4]] = sh[3:0];
    if (cnt == 8 && sh[7]) pend = {4'h0, nreg[sh[6:4]]};
    if (cnt == 8 && sh[7:4] == 4'h3) irq_pend = 1'b0;
    if (cnt == 16 && !sh[15]) breg[sh[11:8]] = sh[7:0];
  end
endmodule // xcvr_model

// ==== dv/tb.sv ====
// self-checking bench for the control serial port master
// assumes the transceiver model answers on the serial pins
`timescale 1ns/10ps
module tb;
  import ctl_port_pkg::*;
  logic        CORE_CLK = 1'b0, RST_B = 1'b0, line_event = 1'b0;
  logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0, RDATA, rv;
  logic [3:0]  WSTRB = 4'hf;
  logic [1:0]  BRESP, RRESP;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, PORT_CLK, PORT_TXD, PORT_RXD;
  logic        PORT_SELECT_ENABLE_B, TRANSCEIVER_RESET_B, LEVEL_ONE_IRQ_INPUT_B;
  logic [7:0]  nib_tx [7] = '{8'h28, 8'h5c, 8'ha0, 8'hd0, 8'h24, 8'ha0, 8'h80};
  logic [7:0]  nib_rx [7] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h0c, 8'h00, 8'h04};
  int          err_count = 0, n_tests = 0, cycles = 0;
  ctl_port_master i_ctl_port_master (.*);
  xcvr_model i_xcvr_model (.*);
  initial forever #2 CORE_CLK = ~CORE_CLK;
  // =====
  // shared tasks
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic aw;
    logic w;
    @(posedge CORE_CLK);
    aw = 1'b1;
    w = 1'b1;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    forever
    begin
      @(posedge CORE_CLK);
      if (aw && AWREADY)
      begin
        aw = 1'b0;
        AWVALID <= 1'b0;
      end
      if (w && WREADY)
      begin
        w = 1'b0;
        WVALID <= 1'b0;
      end
      if (BVALID)
      begin
        BREADY <= 1'b0;
        chk({30'h0, BRESP}, {30'h0, er});
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge CORE_CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    forever
    begin
      @(posedge CORE_CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
      if (RVALID)
      begin
        RREADY <= 1'b0;
        d = RDATA;
        chk({30'h0, RRESP}, {30'h0, er});
        break;
      end
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] s;
    rd(a, s);
    chk(s, exp);
  endtask
  task automatic xfer(input logic [15:0] tx, input logic two);
    logic [31:0] s;
    wr(OFS_PINS, 32'h1);
    wr(OFS_TXDATA, {16'h0, tx});
    wr(OFS_CTRL, {30'h0, two, 1'b1});
    s = 32'h0;
    while (s[STAT_DONE] !== 1'b1) rd(OFS_STATUS, s);
    wr(OFS_STATUS, 32'h2);
    wr(OFS_PINS, 32'h0);
  endtask
  always @(posedge CORE_CLK)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      err_count++;
      final_report;
    end
  end
  // =====
  // tests
  initial
  begin
    repeat (12) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    rchk(OFS_MODE, {24'h0, MODE_RESET});
    chk({31'h0, PORT_CLK}, 32'h1);
    chk({31'h0, PORT_SELECT_ENABLE_B}, 32'h1);
    rd(8'h40, rv, RESP_SLVERR);
    chk(rv, 32'h0);
    wr(8'h40, 32'h5, RESP_SLVERR);
    wr(OFS_PINS, 32'h2);
    chk({31'h0, TRANSCEIVER_RESET_B}, 32'h0);
    wr(OFS_PINS, 32'h0);
    chk({31'h0, TRANSCEIVER_RESET_B}, 32'h1);
    $display("test reset done");
    wr(OFS_TXDATA, 32'hff);
    repeat (40) @(posedge CORE_CLK);
    chk({31'h0, PORT_CLK}, 32'h1);
    rchk(OFS_STATUS, 32'h0);
    xfer(16'h070c, 1'b1);
    xfer(16'hf700, 1'b1);
    rchk(OFS_RXDATA, 32'h0c);
    xfer(16'h0704, 1'b1);
    xfer(16'hf700, 1'b1);
    rchk(OFS_RXDATA, 32'h04);
    $display("test byte access done");
    foreach (nib_tx[i])
    begin
      xfer({8'h00, nib_tx[i]}, 1'b0);
      rchk(OFS_RXDATA, {24'h0, nib_rx[i]});
    end
    $display("test nibble access done");
    xfer(16'h0041, 1'b0);
    line_event <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    rchk(OFS_STATUS, 32'h4);
    xfer(16'h0030, 1'b0);
    rchk(OFS_STATUS, 32'h0);
    $display("test interrupt done");
    WSTRB <= 4'h2;
    wr(OFS_TXDATA, 32'h0000ab99);
    WSTRB <= 4'hf;
    rchk(OFS_TXDATA, 32'h0000ab30);
    wr(OFS_MODE, 32'h0f);
    @(posedge CORE_CLK);
    chk({31'h0, PORT_CLK}, 32'h0);
    $display("test clock mode done");
    final_report;
  end
endmodule // tb
